/* File: core/smc_pkg.sv */
package smc_pkg;
    localparam logic [11:0] ADDR_CTRL   = 12'h000;
    localparam logic [11:0] ADDR_STATUS = 12'h004;
    localparam logic [11:0] ADDR_SRC    = 12'h008;

    localparam int SE_BIT    = 0;
    localparam int SM_LSB    = 1;
    localparam int SM_MSB    = 3;
    localparam logic [7:0] CTRL_RESET = 8'h00;

    localparam logic [2:0] MODE_IDLE    = 3'h0;
    localparam logic [2:0] MODE_ADCNR   = 3'h1;
    localparam logic [2:0] MODE_PDOWN   = 3'h2;
    localparam logic [2:0] MODE_PSAVE   = 3'h3;
    localparam logic [2:0] MODE_STANDBY = 3'h6;

    // halt after wake beyond start-up
    localparam int WAKE_HALT_CYC    = 4;
    // standby restart in clock cycles
    localparam int STANDBY_WAKE_CYC = 6;
    localparam int CNT_W            = 16;

    typedef enum logic [3:0] {
        SMC_RUN   = 4'b0001,
        SMC_SLEEP = 4'b0010,
        SMC_START = 4'b0100,
        SMC_HALT  = 4'b1000
    } smc_state_t;
endpackage

/* File: core/smc_sleep_ctrl.sv */
// Functional notes
// [R1] sleep needs enable bit plus sleep instruction
// [R2] mode field selects among five sleep modes
// [R3] core halted four cycles after start-up
// [R4] register file and sram kept intact
// [R5] reset during sleep restarts at reset vector
// [R6] control register layout, upper bits zero
// [R7] software sets enable just before sleeping
// [R8] idle stops only core and flash clocks
// [R9] idle or noise mode starts adc conversion
// [R10] noise mode also stops io clock
// [R11] noise mode wake sources limited
// [R12] power-down stops main oscillator, all clocks
// [R13] power-down wake sources limited
// [R14] power-down wake waits start-up time
// [R15] level wake held long enough externally
// [R16] power-save keeps timer2 and display running
// [R17] timer2 wake needs its enable and global
// [R18] power-save oscillators stop when unused
// [R19] standby keeps oscillator, six cycle wake
// [R20] timer oscillator in idle only if async
// [R21] idle wakes on any enabled interrupt
// [R22] software picks proper deep mode
// [R23] reserved mode code leaves core running
// [R24] standby without crystal acts as power-down
`timescale 1ns/1ps
module smc_sleep_ctrl
(
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [11:0]               paddr,
    input  wire logic [31:0]               pwdata,
    output logic                           pready,
    output logic                           pslverr,
    output logic [31:0]                    prdata,
    input  wire logic                      sleep_instr,
    input  wire logic                      core_reset,
    input  wire logic                      ext_crystal,
    input  wire logic [smc_pkg::CNT_W-1:0] startup_cycles,
    input  wire logic                      adc_enabled,
    input  wire logic                      tmr2_running,
    input  wire logic                      tmr2_async,
    input  wire logic                      lcd_running,
    input  wire logic                      lcd_async,
    input  wire logic                      global_irq_en,
    input  wire logic                      tmr2_ovf_irq,
    input  wire logic                      tmr2_cmp_irq,
    input  wire logic                      tmr2_ovf_en,
    input  wire logic                      tmr2_cmp_en,
    input  wire logic                      adc_done_irq,
    input  wire logic                      lcd_irq,
    input  wire logic                      usi_start_irq,
    input  wire logic                      eeprom_rdy_irq,
    input  wire logic                      external_irq_zero_level_irq,
    input  wire logic                      external_irq_zero_edge_irq,
    input  wire logic                      pin_change_irq,
    input  wire logic                      other_io_irq,
    output logic                           clk_cpu_en,
    output logic                           clk_flash_en,
    output logic                           clk_io_en,
    output logic                           clk_adc_en,
    output logic                           async_clock_en,
    output logic                           main_osc_en,
    output logic                           timer_osc_en,
    output logic                           adc_start,
    output logic                           core_halted,
    output logic                           wake_irq_take
);
    smc_pkg::smc_state_t            state_q;
    smc_pkg::smc_state_t            state_d;
    logic [2:0]                     mode_q;
    logic                           se_q;
    logic [2:0]                     act_mode_q;
    logic [smc_pkg::CNT_W-1:0]      cnt_q;
    logic [smc_pkg::CNT_W-1:0]      cnt_d;
    logic                           wake;
    logic                           mode_ok;
    logic                           enter;
    logic [2:0]                     eff_mode;
    logic                           wr_en;
    logic                           rd_en;
    logic                           addr_ok;
    logic                           t2_wake;
    logic                           async_use;
    logic [smc_pkg::CNT_W-1:0]      restart_cnt;

    assign wr_en   = psel & penable & pwrite;
    assign rd_en   = psel & ~penable & ~pwrite;
    assign addr_ok = (paddr == smc_pkg::ADDR_CTRL) || (paddr == smc_pkg::ADDR_STATUS)
                     || (paddr == smc_pkg::ADDR_SRC);
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~addr_ok;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            se_q   <= smc_pkg::CTRL_RESET[smc_pkg::SE_BIT];
            mode_q <= smc_pkg::CTRL_RESET[smc_pkg::SM_MSB:smc_pkg::SM_LSB];
        end
        else if (wr_en && paddr == smc_pkg::ADDR_CTRL)
        begin
            se_q   <= pwdata[smc_pkg::SE_BIT]; // R6
            mode_q <= pwdata[smc_pkg::SM_MSB:smc_pkg::SM_LSB]; // R6
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0;
        else if (rd_en)
        begin
            case (paddr)
                smc_pkg::ADDR_CTRL:   prdata <= {28'h0, mode_q, se_q}; // R6
                smc_pkg::ADDR_STATUS: prdata <= {25'h0, act_mode_q, state_q};
                smc_pkg::ADDR_SRC:    prdata <= {31'h0, ext_crystal};
                default:              prdata <= 32'h0;
            endcase
        end
    end

    // reserved codes never enter; standby falls back without a crystal
    always_comb
    begin
        eff_mode = mode_q;
        mode_ok  = 1'b1;
        case (mode_q)
            smc_pkg::MODE_IDLE, smc_pkg::MODE_ADCNR,
            smc_pkg::MODE_PDOWN, smc_pkg::MODE_PSAVE: mode_ok = 1'b1; // R2
            smc_pkg::MODE_STANDBY:
                if (!ext_crystal)
                    eff_mode = smc_pkg::MODE_PDOWN; // R24
            default: mode_ok = 1'b0; // R23
        endcase
    end

    assign enter     = sleep_instr & se_q & mode_ok; // R1
    assign async_use = (tmr2_running & tmr2_async) | (lcd_running & lcd_async);
    assign t2_wake   = global_irq_en & ((tmr2_ovf_irq & tmr2_ovf_en)
                       | (tmr2_cmp_irq & tmr2_cmp_en)); // R17

    always_comb
    begin
        wake = 1'b0;
        case (act_mode_q)
            smc_pkg::MODE_IDLE:
                wake = t2_wake | adc_done_irq | lcd_irq | usi_start_irq | eeprom_rdy_irq
                       | external_irq_zero_level_irq | external_irq_zero_edge_irq | pin_change_irq
                       | other_io_irq; // R21
            smc_pkg::MODE_ADCNR:
                wake = adc_done_irq | usi_start_irq | eeprom_rdy_irq | external_irq_zero_level_irq
                       | pin_change_irq | (async_use & (lcd_irq | t2_wake)); // R11 R20
            smc_pkg::MODE_PSAVE:
                wake = usi_start_irq | external_irq_zero_level_irq | pin_change_irq
                       | (lcd_running & lcd_irq) | (tmr2_running & t2_wake); // R16 R17
            default:
                wake = usi_start_irq | external_irq_zero_level_irq | pin_change_irq; // R13
        endcase
    end

    // standby only needs the fixed restart; deep modes use the fuse time-out
    assign restart_cnt = (act_mode_q == smc_pkg::MODE_STANDBY)
                         ? smc_pkg::CNT_W'(smc_pkg::STANDBY_WAKE_CYC) // R19
                         : (act_mode_q == smc_pkg::MODE_PDOWN
                            || act_mode_q == smc_pkg::MODE_PSAVE)
                           ? startup_cycles : smc_pkg::CNT_W'(0); // R14

    always_comb
    begin
        state_d = state_q;
        cnt_d   = cnt_q;
        case (state_q)
            smc_pkg::SMC_RUN:
                if (enter)
                    state_d = smc_pkg::SMC_SLEEP;
            smc_pkg::SMC_SLEEP:
                if (wake)
                begin
                    if (restart_cnt != '0)
                    begin
                        state_d = smc_pkg::SMC_START;
                        cnt_d   = restart_cnt;
                    end
                    else
                    begin
                        state_d = smc_pkg::SMC_HALT;
                        cnt_d   = smc_pkg::CNT_W'(smc_pkg::WAKE_HALT_CYC); // R3
                    end
                end
            smc_pkg::SMC_START:
            begin
                cnt_d = cnt_q - 1'b1;
                if (cnt_q == smc_pkg::CNT_W'(1))
                begin
                    state_d = smc_pkg::SMC_HALT;
                    cnt_d   = smc_pkg::CNT_W'(smc_pkg::WAKE_HALT_CYC); // R3
                end
            end
            smc_pkg::SMC_HALT:
            begin
                cnt_d = cnt_q - 1'b1;
                if (cnt_q == smc_pkg::CNT_W'(1))
                    state_d = smc_pkg::SMC_RUN;
            end
            default: state_d = smc_pkg::SMC_RUN;
        endcase
    end

    // core reset drops straight to run so execution restarts at the reset vector
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q <= smc_pkg::SMC_RUN;
            cnt_q   <= '0;
        end
        else if (core_reset)
        begin
            state_q <= smc_pkg::SMC_RUN; // R5
            cnt_q   <= '0;
        end
        else
        begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            act_mode_q <= smc_pkg::MODE_IDLE;
        else if (state_q == smc_pkg::SMC_RUN && enter)
            act_mode_q <= eff_mode;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            adc_start     <= 1'b0;
            wake_irq_take <= 1'b0;
        end
        else
        begin
            adc_start <= state_q == smc_pkg::SMC_RUN && enter && adc_enabled
                         && (eff_mode == smc_pkg::MODE_IDLE
                             || eff_mode == smc_pkg::MODE_ADCNR); // R9
            // only a normal wake resumes via the handler, not a reset
            wake_irq_take <= state_q == smc_pkg::SMC_HALT && cnt_q == smc_pkg::CNT_W'(1)
                             && !core_reset; // R3
        end
    end

    // gating only stops clocks; storage is never cleared here
    always_comb
    begin
        clk_cpu_en   = 1'b1;
        clk_flash_en = 1'b1;
        clk_io_en    = 1'b1;
        clk_adc_en   = 1'b1;
        async_clock_en   = 1'b1;
        main_osc_en  = 1'b1;
        timer_osc_en = async_use;
        if (state_q == smc_pkg::SMC_SLEEP) // R4
        begin
            clk_cpu_en   = 1'b0; // R8
            clk_flash_en = 1'b0;
            case (act_mode_q)
                smc_pkg::MODE_IDLE:
                    timer_osc_en = async_use; // R20
                smc_pkg::MODE_ADCNR:
                begin
                    clk_io_en    = 1'b0; // R10
                    timer_osc_en = async_use; // R20
                end
                smc_pkg::MODE_PSAVE:
                begin
                    clk_io_en    = 1'b0;
                    clk_adc_en   = 1'b0;
                    main_osc_en  = (tmr2_running & ~tmr2_async)
                                   | (lcd_running & ~lcd_async); // R18
                    timer_osc_en = async_use; // R18
                end
                smc_pkg::MODE_STANDBY:
                begin
                    clk_io_en    = 1'b0;
                    clk_adc_en   = 1'b0;
                    async_clock_en   = 1'b0;
                    main_osc_en  = 1'b1; // R19
                    timer_osc_en = 1'b0;
                end
                default:
                begin
                    clk_io_en    = 1'b0; // R12
                    clk_adc_en   = 1'b0;
                    async_clock_en   = 1'b0;
                    main_osc_en  = 1'b0;
                    timer_osc_en = 1'b0;
                end
            endcase
        end
        else if (state_q == smc_pkg::SMC_START)
        begin
            clk_cpu_en   = 1'b0;
            clk_flash_en = 1'b0;
        end
    end

    assign core_halted = state_q != smc_pkg::SMC_RUN;

    property p_no_sleep_without_se;
        @(posedge pclk) disable iff (!presetn)
        (state_q == smc_pkg::SMC_RUN && !se_q && !core_reset) |=> state_q == smc_pkg::SMC_RUN;
    endproperty
    a_no_sleep_without_se: assert property (p_no_sleep_without_se) // R1
        else $error("sleep entered without enable");

    property p_reserved_stays;
        @(posedge pclk) disable iff (!presetn)
        (state_q == smc_pkg::SMC_RUN && (mode_q == 3'h4 || mode_q == 3'h5 || mode_q == 3'h7))
        |=> state_q == smc_pkg::SMC_RUN;
    endproperty
    a_reserved_stays: assert property (p_reserved_stays) // R23
        else $error("reserved mode entered sleep");

    property p_halt_four;
        @(posedge pclk) disable iff (!presetn || core_reset)
        $rose(state_q == smc_pkg::SMC_HALT) |-> (state_q == smc_pkg::SMC_HALT)[*4]
        ##1 state_q == smc_pkg::SMC_RUN;
    endproperty
    a_halt_four: assert property (p_halt_four) // R3
        else $error("halt not four cycles");

    property p_reset_wakes;
        @(posedge pclk) disable iff (!presetn)
        core_reset |=> state_q == smc_pkg::SMC_RUN && !wake_irq_take;
    endproperty
    a_reset_wakes: assert property (p_reset_wakes) // R5
        else $error("reset did not wake");

    property p_idle_clocks;
        @(posedge pclk) disable iff (!presetn)
        (state_q == smc_pkg::SMC_SLEEP && act_mode_q == smc_pkg::MODE_IDLE)
        |-> !clk_cpu_en && !clk_flash_en && clk_io_en && clk_adc_en && main_osc_en;
    endproperty
    a_idle_clocks: assert property (p_idle_clocks) // R8
        else $error("idle gating wrong");

    property p_pdown_off;
        @(posedge pclk) disable iff (!presetn)
        (state_q == smc_pkg::SMC_SLEEP && act_mode_q == smc_pkg::MODE_PDOWN)
        |-> !main_osc_en && !clk_io_en && !async_clock_en;
    endproperty
    a_pdown_off: assert property (p_pdown_off) // R12
        else $error("power-down clocks running");

    property p_standby_six;
        @(posedge pclk) disable iff (!presetn || core_reset)
        (state_q == smc_pkg::SMC_SLEEP && act_mode_q == smc_pkg::MODE_STANDBY && wake)
        |=> (state_q == smc_pkg::SMC_START)[*6] ##1 state_q == smc_pkg::SMC_HALT;
    endproperty
    a_standby_six: assert property (p_standby_six) // R19
        else $error("standby wake not six cycles");

    property p_pdown_edge_ignored;
        @(posedge pclk) disable iff (!presetn || core_reset)
        (state_q == smc_pkg::SMC_SLEEP && act_mode_q == smc_pkg::MODE_PDOWN
         && external_irq_zero_edge_irq && !usi_start_irq && !external_irq_zero_level_irq && !pin_change_irq)
        |=> state_q == smc_pkg::SMC_SLEEP;
    endproperty
    a_pdown_edge_ignored: assert property (p_pdown_edge_ignored) // R13
        else $error("edge woke power-down");

    property p_adc_start;
        @(posedge pclk) disable iff (!presetn)
        (state_q == smc_pkg::SMC_RUN && enter && adc_enabled && eff_mode == smc_pkg::MODE_ADCNR)
        |=> adc_start;
    endproperty
    a_adc_start: assert property (p_adc_start) // R9
        else $error("no adc start on entry");

    c_idle_wake: cover property (@(posedge pclk) disable iff (!presetn)
        state_q == smc_pkg::SMC_SLEEP && act_mode_q == smc_pkg::MODE_IDLE ##1
        state_q == smc_pkg::SMC_HALT);
    c_pdown_wake: cover property (@(posedge pclk) disable iff (!presetn)
        state_q == smc_pkg::SMC_SLEEP && act_mode_q == smc_pkg::MODE_PDOWN ##1
        state_q == smc_pkg::SMC_START);
    c_reset_sleep: cover property (@(posedge pclk) disable iff (!presetn)
        state_q == smc_pkg::SMC_SLEEP && core_reset);
endmodule // smc_sleep_ctrl

/* File: tb/smc_core_model.sv */
`timescale 1ns/1ps
module smc_core_model
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       exec_sleep,
    input  wire logic [9:0] irq_arm,
    input  wire logic       core_halted,
    input  wire logic       wake_irq_take,
    input  wire logic       core_reset,
    output logic            sleep_instr,
    output logic [9:0]      irq_lines
);
    // a halted core fetches nothing, so it cannot issue another sleep
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            sleep_instr <= 1'b0;
        else
            sleep_instr <= exec_sleep & ~core_halted;
    end

    // flags stay pending until the handler runs, so a level wake is held
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_lines <= 10'h000;
        else if (wake_irq_take || core_reset)
            irq_lines <= 10'h000;
        else
            irq_lines <= irq_lines | irq_arm;
    end
endmodule // smc_core_model

/* File: tb/testbench.sv */
`timescale 1ns/1ps
module testbench;
    localparam int I_OVF = 9;
    localparam int I_ADC = 7;
    localparam int I_LVL = 3;
    localparam int I_EDGE = 2;
    localparam int I_PIN = 1;
    localparam int I_IO = 0;
    localparam int HC = smc_pkg::WAKE_HALT_CYC;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic        pready, pslverr, sleep_instr, core_reset = 1'b0, ext_crystal = 1'b0;
    logic [15:0] startup_cycles = 16'h0003;
    logic        adc_enabled = 1'b1, tmr2_running = 1'b0, tmr2_async = 1'b0;
    logic        lcd_running = 1'b0, lcd_async = 1'b0, global_irq_en = 1'b0;
    logic        tmr2_ovf_en = 1'b0, tmr2_cmp_en = 1'b0, exec_sleep = 1'b0;
    logic [9:0]  irq_arm = 10'h000, irq_lines;
    logic        clk_cpu_en, clk_flash_en, clk_io_en, clk_adc_en, async_clock_en;
    logic        main_osc_en, timer_osc_en, adc_start, core_halted, wake_irq_take;
    int          err_total = 0;
    int          cmp_count = 0;

    always #5 pclk = ~pclk;

    smc_sleep_ctrl u_smc_sleep_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .pslverr(pslverr), .prdata(prdata), .sleep_instr(sleep_instr), .core_reset(core_reset),
        .ext_crystal(ext_crystal), .startup_cycles(startup_cycles), .adc_enabled(adc_enabled),
        .tmr2_running(tmr2_running), .tmr2_async(tmr2_async), .lcd_running(lcd_running),
        .lcd_async(lcd_async), .global_irq_en(global_irq_en), .tmr2_ovf_irq(irq_lines[9]),
        .tmr2_cmp_irq(irq_lines[8]), .tmr2_ovf_en(tmr2_ovf_en), .tmr2_cmp_en(tmr2_cmp_en),
        .adc_done_irq(irq_lines[7]), .lcd_irq(irq_lines[6]), .usi_start_irq(irq_lines[5]),
        .eeprom_rdy_irq(irq_lines[4]), .external_irq_zero_level_irq(irq_lines[3]),
        .external_irq_zero_edge_irq(irq_lines[2]), .pin_change_irq(irq_lines[1]),
        .other_io_irq(irq_lines[0]), .clk_cpu_en(clk_cpu_en), .clk_flash_en(clk_flash_en),
        .clk_io_en(clk_io_en), .clk_adc_en(clk_adc_en), .async_clock_en(async_clock_en),
        .main_osc_en(main_osc_en), .timer_osc_en(timer_osc_en), .adc_start(adc_start),
        .core_halted(core_halted), .wake_irq_take(wake_irq_take));

    smc_core_model u_smc_core_model (.pclk(pclk), .presetn(presetn), .exec_sleep(exec_sleep),
        .irq_arm(irq_arm), .core_halted(core_halted), .wake_irq_take(wake_irq_take),
        .core_reset(core_reset), .sleep_instr(sleep_instr), .irq_lines(irq_lines));

    task automatic wrap_up();
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk_bit(input string what, input logic exp, input logic got);
        cmp_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("unexpected %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_count(input string what, input int exp, input int got);
        cmp_count++;
        if (got != exp)
        begin
            err_total++;
            $display("unexpected %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    // read data is loaded in setup, so it stands at the access edge
    task automatic apb_xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                            output logic [31:0] rd, output logic err);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        if (n >= 50)
        begin
            err_total++;
            wrap_up();
        end
        err = pslverr;
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic go_sleep(input logic [2:0] m, input logic en);
        logic [31:0] rd;
        logic        e;
        apb_xfer(1'b1, smc_pkg::ADDR_CTRL, {28'h0, m, en}, rd, e);
        exec_sleep <= 1'b1;
        @(posedge pclk);
        exec_sleep <= 1'b0;
        @(posedge pclk);
        #1;
    endtask

    task automatic raise(input int idx);
        @(posedge pclk);
        irq_arm <= 10'h001 << idx;
        @(posedge pclk);
        irq_arm <= 10'h000;
    endtask

    task automatic wait_wake(input string what, input int exp);
        int          n;
        logic [31:0] rd;
        logic        e;
        n = 0;
        do
        begin
            @(posedge pclk);
            #1;
            n++;
        end
        while (wake_irq_take !== 1'b1 && n < 400);
        if (n >= 400)
        begin
            err_total++;
            wrap_up();
        end
        chk_count(what, exp, n);
        chk_bit("running after wake", 1'b0, core_halted);
        apb_xfer(1'b1, smc_pkg::ADDR_CTRL, 32'h0, rd, e);
    endtask

    task automatic no_wake(input string what, input int idx);
        raise(idx);
        repeat (8) @(posedge pclk);
        #1;
        chk_bit(what, 1'b1, core_halted);
    endtask

    task automatic t_regs();
        logic [31:0] rd;
        logic        e;
        apb_xfer(1'b0, smc_pkg::ADDR_CTRL, 32'h0, rd, e);
        chk_word("ctrl reset", {24'h0, smc_pkg::CTRL_RESET}, rd);
        apb_xfer(1'b1, smc_pkg::ADDR_CTRL, 32'hffff_ffff, rd, e);
        apb_xfer(1'b0, smc_pkg::ADDR_CTRL, 32'h0, rd, e);
        chk_word("ctrl readback", 32'h0000_000f, rd);
        apb_xfer(1'b0, 12'hffc, 32'h0, rd, e);
        chk_bit("unmapped error", 1'b1, e);
        chk_word("unmapped data", 32'h0, rd);
        $display("test regs done");
    endtask

    task automatic t_gate();
        logic [2:0] rsv [3] = '{3'h4, 3'h5, 3'h7};
        go_sleep(smc_pkg::MODE_IDLE, 1'b0);
        chk_bit("halt without enable", 1'b0, core_halted);
        foreach (rsv[i])
        begin
            go_sleep(rsv[i], 1'b1);
            chk_bit("reserved halt", 1'b0, core_halted);
            chk_bit("reserved cpu clock", 1'b1, clk_cpu_en);
        end
        $display("test gate done");
    endtask

    task automatic t_idle_nr();
        go_sleep(smc_pkg::MODE_IDLE, 1'b1);
        chk_bit("idle halt", 1'b1, core_halted);
        chk_bit("idle cpu clock", 1'b0, clk_cpu_en);
        chk_bit("idle flash clock", 1'b0, clk_flash_en);
        chk_bit("idle io clock", 1'b1, clk_io_en);
        chk_bit("idle async clock", 1'b1, async_clock_en);
        chk_bit("idle adc start", 1'b1, adc_start);
        raise(I_IO);
        wait_wake("idle wake cycles", 1 + HC);
        go_sleep(smc_pkg::MODE_ADCNR, 1'b1);
        chk_bit("noise io clock", 1'b0, clk_io_en);
        chk_bit("noise adc clock", 1'b1, clk_adc_en);
        chk_bit("noise adc start", 1'b1, adc_start);
        no_wake("noise ignores io irq", I_IO);
        raise(I_ADC);
        wait_wake("noise wake cycles", 1 + HC);
        $display("test idle and noise done");
    endtask

    task automatic t_deep();
        go_sleep(smc_pkg::MODE_PDOWN, 1'b1);
        chk_bit("pdown main osc", 1'b0, main_osc_en);
        chk_bit("pdown adc clock", 1'b0, clk_adc_en);
        chk_bit("pdown adc start", 1'b0, adc_start);
        no_wake("pdown ignores edge irq", I_EDGE);
        raise(I_LVL);
        wait_wake("pdown wake cycles", 1 + 3 + HC);
        @(posedge pclk);
        tmr2_ovf_en <= 1'b1;
        tmr2_running <= 1'b1;
        tmr2_async <= 1'b1;
        go_sleep(smc_pkg::MODE_PSAVE, 1'b1);
        chk_bit("psave main osc", 1'b0, main_osc_en);
        chk_bit("psave timer osc", 1'b1, timer_osc_en);
        no_wake("psave needs global enable", I_OVF);
        @(posedge pclk);
        global_irq_en <= 1'b1;
        wait_wake("psave wake cycles", 1 + 3 + HC);
        $display("test deep done");
    endtask

    task automatic t_standby();
        @(posedge pclk);
        ext_crystal <= 1'b1;
        go_sleep(smc_pkg::MODE_STANDBY, 1'b1);
        chk_bit("standby main osc", 1'b1, main_osc_en);
        chk_bit("standby cpu clock", 1'b0, clk_cpu_en);
        raise(I_PIN);
        wait_wake("standby wake cycles", 1 + smc_pkg::STANDBY_WAKE_CYC + HC);
        @(posedge pclk);
        ext_crystal <= 1'b0;
        startup_cycles <= 16'h0002;
        go_sleep(smc_pkg::MODE_STANDBY, 1'b1);
        chk_bit("no crystal main osc", 1'b0, main_osc_en);
        raise(I_PIN);
        wait_wake("no crystal wake cycles", 1 + 2 + HC);
        $display("test standby done");
    endtask

    task automatic t_reset();
        logic [31:0] rd;
        logic        e;
        go_sleep(smc_pkg::MODE_PDOWN, 1'b1);
        chk_bit("sleeping before reset", 1'b1, core_halted);
        @(posedge pclk);
        core_reset <= 1'b1;
        @(posedge pclk);
        core_reset <= 1'b0;
        #1;
        chk_bit("reset wakes core", 1'b0, core_halted);
        chk_bit("reset skips handler", 1'b0, wake_irq_take);
        apb_xfer(1'b1, smc_pkg::ADDR_CTRL, 32'h0, rd, e);
        $display("test reset done");
    endtask

    initial
    begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_gate();
        t_idle_nr();
        t_deep();
        t_standby();
        t_reset();
        wrap_up();
    end
endmodule // testbench
